// ==== rtl/rbr_manager.sv ====
// Bus fault detection, wrap-around checking and recovery for a dual bus controller
//
// Operation
// - Invalid to valid only by command or release
// - Invalid terminal: link and transfer actions off
// - Link fault management enabled by its own control bit, independent of safing
// - Controller failure with valid terminal: bus unhealthy
// - Recover if alternate healthy, else alarm
// - Raise bus-anomaly event on unhealthy declaration
// - Muted: hold commands, no telemetry, sync runs
// - Suspend transfer layer during recovery
// - Wrap test every valid terminal, alternate then current
// - Write slot N, read slot N plus offset
// - Switch only if alternate good, current bad
// - Recovery finishes within 250 ms
// - Unmute at next subframe after recovery
// - Re-enable transfer layer after recovery
// - Repeat last command message
// - Repeat last packet unless confirmed
// - Repeated packet keeps original 8-bit count
// - One bad non-vital terminal: its fault; more, or a vital one: alarm
// - Store bus health periodically in safeguard
// - Commands set each bus health independently
// - Survival bus side held write protected
// - Status word bits go to transfer layer
// - Broadcast sync at 64 Hz
// - No response after 14 us flags timeout
// - Vital flag per terminal, set by command
// - Valid flag per terminal
// - Roles of buses swap with active bus
`timescale 1ns/1ps
`default_nettype none
module rbr_manager
    import rbr_pkg::*;
#(
    parameter int SYNC_CYCLES  = rbr_pkg::SYNC_CYC,
    parameter int RECOV_CYCLES = rbr_pkg::RECOV_CYC,
    parameter logic [rbr_pkg::RT_W-1:0] VCT_RT = rbr_pkg::VCT_RT_DEF
) (
    // Clock and reset
    input  wire logic                        sys_clk_in,
    input  wire logic                        resetn_in,
    // Register port
    input  wire logic [rbr_pkg::ADDR_W-1:0]  reg_addr_in,
    input  wire logic [31:0]                 reg_wdata_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    output logic      [31:0]                 reg_rdata_out,
    // Bus interface reports
    input  wire rbr_pkg::rbr_txn_t           txn_in,
    input  wire logic                        cmd_sent_in,
    input  wire logic [rbr_pkg::RT_W-1:0]    cmd_rt_in,
    input  wire logic                        resp_in,
    input  wire logic                        slot_tick_in,
    input  wire rbr_pkg::rbr_wres_t          wrap_res_in,
    // Command traffic tracking
    input  wire logic                        tc_msg_sent_in,
    input  wire logic                        tc_pkt_sent_in,
    input  wire logic [rbr_pkg::CNT_W-1:0]   ptd_count_in,
    input  wire logic                        ptc_ok_in,
    // Reset release and stored context
    input  wire logic                        reset_release_signal_in,
    input  wire logic                        ctx_valid_in,
    input  wire logic [1:0]                  ctx_health_in,
    input  wire logic                        ctx_active_in,
    // Bus engine control
    output rbr_pkg::rbr_wrap_t               wrap_out,
    output logic                             active_bus_out,
    output logic                             mute_out,
    output logic                             sync_out,
    output logic [rbr_pkg::N_RT-1:0]         tfl_enable_out,
    // Events
    output logic                             bus_event_out,
    output logic                             alarm3_out,
    output logic                             subsys_fault_out,
    output logic                             anomaly_out,
    output logic [rbr_pkg::RT_W-1:0]         event_rt_out,
    output logic                             rep_msg_out,
    output logic                             rep_pkt_out,
    output logic [rbr_pkg::CNT_W-1:0]        rep_count_out,
    // Safeguard and survival context
    output logic                             sgm_wr_out,
    output logic [2:0]                       sgm_data_out,
    output logic                             surv_bus_out
);
    import rbr_pkg::*;

    rbr_state_t       st_q;
    logic [2:0]       ctrl_q;
    logic [1:0]       health_q;
    logic             act_q;
    logic             mute_q;
    logic             susp_q;
    logic             restore_q;
    logic [N_RT-1:0]  valid_q;
    logic [N_RT-1:0]  vital_q;
    logic [N_RT-1:0]  fail_alt_q;
    logic [N_RT-1:0]  fail_cur_q;
    logic [RT_W-1:0]  rt_q;
    logic [RT_W-1:0]  bad_rt_q;
    logic             pass_q;
    logic [GAP_W-1:0] gap_q;
    logic [GAP_W-1:0] gcnt_q;
    logic [31:0]      wdog_q;
    logic [31:0]      sync_cnt_q;
    logic             surv_q;
    logic             rr_q;
    logic             have_msg_q;
    logic             pkt_pend_q;
    logic [CNT_W-1:0] cnt_q;
    logic [15:0]      nr_cnt_q;
    logic             nr_run_q;
    logic [RT_W-1:0]  nr_rt_q;

    logic wr_ctrl, wr_health, wr_vset, wr_vclr, wr_vital, wr_surv, wr_gap;
    logic sf_tick, rr_fall, nr_fire, ctrl_fail, fault_det, last_rt, alt_ok, cur_ok;
    logic multi_alt;

    assign wr_ctrl   = reg_wr_in && reg_addr_in == A_CTRL;
    assign wr_health = reg_wr_in && reg_addr_in == A_HEALTH;
    assign wr_vset   = reg_wr_in && reg_addr_in == A_VALID_SET;
    assign wr_vclr   = reg_wr_in && reg_addr_in == A_VALID_CLR;
    assign wr_vital  = reg_wr_in && reg_addr_in == A_VITAL;
    assign wr_surv   = reg_wr_in && reg_addr_in == A_SURV;
    assign wr_gap    = reg_wr_in && reg_addr_in == A_GAP;

    assign sf_tick = sync_cnt_q == 32'(SYNC_CYCLES - 1);
    assign rr_fall = rr_q && !reset_release_signal_in;
    assign nr_fire = nr_run_q && nr_cnt_q == 16'h0001;
    assign ctrl_fail = (txn_in.vld && (txn_in.tx_err || txn_in.loop_fail) && valid_q[txn_in.rt])
                     || (nr_fire && valid_q[nr_rt_q]);
    assign fault_det = ctrl_fail && ctrl_q[C_DLL_EN] && !restore_q;
    assign last_rt   = rt_q == RT_W'(N_RT - 1);
    assign alt_ok    = fail_alt_q == '0;
    assign cur_ok    = fail_cur_q == '0;
    assign multi_alt = (fail_alt_q & (fail_alt_q - 1'b1)) != '0;

    // Control register; link fault management enable is independent of safing
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata_in[2:0];
        end
    end

    // Per-terminal valid flags
    for (genvar i = 0; i < N_RT; i++) begin : g_valid
        always_ff @(posedge sys_clk_in) begin
            if (!resetn_in) begin
                valid_q[i] <= VALID_RST[i];
            end else if ((wr_vset && reg_wdata_in[i]) || (i == int'(VCT_RT) && rr_fall)) begin
                valid_q[i] <= 1'b1;
            end else if (wr_vclr && reg_wdata_in[i]) begin
                valid_q[i] <= 1'b0;
            end
        end
    end

    // Vital flags, slot gap and survival side
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            vital_q <= '0;
            gap_q   <= GAP_RST;
            surv_q  <= 1'b0;
            rr_q    <= 1'b0;
        end else begin
            rr_q <= reset_release_signal_in;
            if (wr_vital) begin
                vital_q <= reg_wdata_in;
            end
            if (wr_gap && reg_wdata_in[GAP_W-1:0] != '0) begin
                gap_q <= reg_wdata_in[GAP_W-1:0];
            end
            if (wr_surv && ctrl_q[C_UNLOCK]) begin
                surv_q <= reg_wdata_in[0];
            end
        end
    end

    // Sync broadcast divider, runs even while muted
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sync_cnt_q <= '0;
            sync_out   <= 1'b0;
        end else begin
            sync_cnt_q <= sf_tick ? '0 : sync_cnt_q + 32'h1;
            sync_out   <= sf_tick;
        end
    end

    // No-response timer
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            nr_run_q <= 1'b0;
            nr_cnt_q <= '0;
            nr_rt_q  <= '0;
        end else if (cmd_sent_in) begin
            nr_run_q <= 1'b1;
            nr_cnt_q <= 16'(NORESP_CYC);
            nr_rt_q  <= cmd_rt_in;
        end else if (resp_in || nr_fire) begin
            nr_run_q <= 1'b0;
        end else if (nr_run_q) begin
            nr_cnt_q <= nr_cnt_q - 16'h1;
        end
    end

    // Last command tracking; a new send wins over a confirmation
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            have_msg_q <= 1'b0;
            pkt_pend_q <= 1'b0;
            cnt_q      <= '0;
        end else if (!mute_q) begin
            if (tc_msg_sent_in) begin
                have_msg_q <= 1'b1;
            end
            if (tc_pkt_sent_in) begin
                pkt_pend_q <= 1'b1;
                cnt_q      <= ptd_count_in;
            end else if (ptc_ok_in) begin
                pkt_pend_q <= 1'b0;
            end
        end
    end

    // Status-word anomalies, forwarded only for valid terminals outside recovery
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            anomaly_out <= 1'b0;
        end else begin
            anomaly_out <= txn_in.vld && valid_q[txn_in.rt] && !susp_q
                        && (txn_in.msg_err || txn_in.busy || txn_in.subsys || txn_in.term);
        end
    end

    // Transfer layer enables per terminal
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            tfl_enable_out <= '0;
        end else begin
            tfl_enable_out <= valid_q & {N_RT{!susp_q}};
        end
    end

    // Safeguard snapshot once per subframe
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sgm_wr_out   <= 1'b0;
            sgm_data_out <= '0;
            surv_bus_out <= 1'b0;
        end else begin
            sgm_wr_out   <= sf_tick;
            sgm_data_out <= {act_q, health_q};
            surv_bus_out <= surv_q;
        end
    end

    // Recovery sequencer
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            st_q <= S_IDLE;
            health_q <= HEALTH_RST;
            act_q <= 1'b0;
            mute_q <= 1'b0;
            susp_q <= 1'b0;
            restore_q <= 1'b1;
            fail_alt_q <= '0;
            fail_cur_q <= '0;
            rt_q <= '0;
            bad_rt_q <= '0;
            pass_q <= 1'b0;
            gcnt_q <= '0;
            wdog_q <= '0;
            wrap_out <= '0;
            bus_event_out <= 1'b0;
            alarm3_out <= 1'b0;
            subsys_fault_out <= 1'b0;
            event_rt_out <= '0;
            rep_msg_out <= 1'b0;
            rep_pkt_out <= 1'b0;
            rep_count_out <= '0;
        end else begin
            wrap_out.wr <= 1'b0;
            wrap_out.rd <= 1'b0;
            bus_event_out <= 1'b0;
            alarm3_out <= 1'b0;
            subsys_fault_out <= 1'b0;
            rep_msg_out <= 1'b0;
            rep_pkt_out <= 1'b0;
            restore_q <= 1'b0;
            wdog_q <= (st_q == S_IDLE || st_q == S_ALARM) ? '0 : wdog_q + 32'h1;
            if (restore_q && ctx_valid_in) begin
                health_q <= ctx_health_in;
                act_q <= ctx_active_in;
            end
            if (wr_health) begin
                health_q <= reg_wdata_in[1:0];
            end
            case (st_q)
                S_IDLE: begin
                    if (fault_det) begin
                        health_q[act_q] <= 1'b0;
                        bus_event_out <= 1'b1;
                        event_rt_out <= txn_in.vld ? txn_in.rt : nr_rt_q;
                        if (health_q[!act_q]) begin
                            mute_q <= 1'b1;
                            susp_q <= 1'b1;
                            fail_alt_q <= '0;
                            fail_cur_q <= '0;
                            rt_q <= '0;
                            pass_q <= 1'b0;
                            st_q <= S_SCAN;
                        end else begin
                            alarm3_out <= 1'b1;
                            st_q <= S_ALARM;
                        end
                    end
                end
                S_SCAN: begin
                    if (!valid_q[rt_q]) begin
                        if (!last_rt) begin
                            rt_q <= rt_q + 1'b1;
                        end else if (!pass_q) begin
                            pass_q <= 1'b1;
                            rt_q <= '0;
                        end else begin
                            st_q <= S_EVAL;
                        end
                    end else if (slot_tick_in) begin
                        wrap_out.wr <= 1'b1;
                        wrap_out.bus <= pass_q ? act_q : !act_q;
                        wrap_out.rt <= rt_q;
                        gcnt_q <= gap_q;
                        st_q <= S_GAP;
                    end
                end
                S_GAP: begin
                    if (slot_tick_in) begin
                        gcnt_q <= gcnt_q - 1'b1;
                        if (gcnt_q == GAP_W'(1)) begin
                            wrap_out.rd <= 1'b1;
                            st_q <= S_RES;
                        end
                    end
                end
                S_RES: begin
                    if (wrap_res_in.done) begin
                        if (!wrap_res_in.pass && pass_q) begin
                            fail_cur_q[rt_q] <= 1'b1;
                        end
                        if (!wrap_res_in.pass && !pass_q) begin
                            fail_alt_q[rt_q] <= 1'b1;
                            bad_rt_q <= rt_q;
                        end
                        if (!last_rt) begin
                            rt_q <= rt_q + 1'b1;
                            st_q <= S_SCAN;
                        end else if (!pass_q) begin
                            pass_q <= 1'b1;
                            rt_q <= '0;
                            st_q <= S_SCAN;
                        end else begin
                            st_q <= S_EVAL;
                        end
                    end
                end
                S_EVAL: begin
                    if (alt_ok && !cur_ok) begin
                        act_q <= !act_q;
                        st_q <= S_UNMUTE;
                    end else if (alt_ok) begin
                        health_q[act_q] <= 1'b1;
                        st_q <= S_UNMUTE;
                    end else if (!multi_alt && !vital_q[bad_rt_q]) begin
                        health_q[!act_q] <= 1'b0;
                        subsys_fault_out <= 1'b1;
                        event_rt_out <= bad_rt_q;
                        st_q <= S_UNMUTE;
                    end else begin
                        health_q[!act_q] <= 1'b0;
                        alarm3_out <= 1'b1;
                        st_q <= S_ALARM;
                    end
                end
                S_UNMUTE: begin
                    if (sf_tick) begin
                        mute_q <= 1'b0;
                        susp_q <= 1'b0;
                        rep_msg_out <= have_msg_q;
                        rep_pkt_out <= pkt_pend_q;
                        rep_count_out <= cnt_q;
                        st_q <= S_IDLE;
                    end
                end
                S_ALARM: begin
                    if (wr_health) begin
                        mute_q <= 1'b0;
                        susp_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
            if (st_q != S_IDLE && st_q != S_ALARM && wdog_q == 32'(RECOV_CYCLES - 1)) begin
                alarm3_out <= 1'b1;
                st_q <= S_ALARM;
            end
        end
    end

    // Engine-facing copies
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            active_bus_out <= 1'b0;
            mute_out <= 1'b0;
        end else begin
            active_bus_out <= act_q;
            mute_out <= mute_q;
        end
    end

    // Read port, data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= '0;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= '0;
        end else begin
            case (reg_addr_in)
                A_CTRL:      reg_rdata_out <= {29'h0, ctrl_q};
                A_HEALTH:    reg_rdata_out <= {30'h0, health_q};
                A_VALID_SET: reg_rdata_out <= valid_q;
                A_VALID_CLR: reg_rdata_out <= valid_q;
                A_VITAL:     reg_rdata_out <= vital_q;
                A_STATUS:    reg_rdata_out <= {24'h0, pass_q, st_q, susp_q, mute_q, act_q, restore_q};
                A_WFAIL:     reg_rdata_out <= fail_alt_q;
                A_SURV:      reg_rdata_out <= {31'h0, surv_q};
                A_GAP:       reg_rdata_out <= {28'h0, gap_q};
                A_LASTTC:    reg_rdata_out <= {22'h0, have_msg_q, pkt_pend_q, cnt_q};
                default:     reg_rdata_out <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== rtl/rbr_pkg.sv ====
// Package: constants and types for the redundant bus recovery manager
package rbr_pkg;
    localparam int CLK_HZ     = 40_000_000;
    localparam int SYNC_HZ    = 64;
    localparam int SYNC_CYC   = CLK_HZ / SYNC_HZ;
    localparam int NORESP_NS  = 14_000;
    localparam int NORESP_CYC = (NORESP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RECOV_MS   = 250;
    localparam int RECOV_CYC  = RECOV_MS * (CLK_HZ / 1000);

    localparam int N_RT   = 32;
    localparam int RT_W   = 5;
    localparam int ADDR_W = 8;
    localparam int CNT_W  = 8;
    localparam int GAP_W  = 4;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] A_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] A_HEALTH    = 8'h04;
    localparam logic [ADDR_W-1:0] A_VALID_SET = 8'h08;
    localparam logic [ADDR_W-1:0] A_VALID_CLR = 8'h0c;
    localparam logic [ADDR_W-1:0] A_VITAL     = 8'h10;
    localparam logic [ADDR_W-1:0] A_STATUS    = 8'h14;
    localparam logic [ADDR_W-1:0] A_WFAIL     = 8'h18;
    localparam logic [ADDR_W-1:0] A_SURV      = 8'h1c;
    localparam logic [ADDR_W-1:0] A_GAP       = 8'h20;
    localparam logic [ADDR_W-1:0] A_LASTTC    = 8'h24;

    // Control fields
    localparam int C_SAFING = 0;
    localparam int C_DLL_EN = 1;
    localparam int C_UNLOCK = 2;
    localparam logic [2:0] CTRL_RST = 3'h2;
    localparam logic [1:0] HEALTH_RST = 2'h3;
    localparam logic [N_RT-1:0] VALID_RST = 32'hffff_ffff;
    localparam logic [GAP_W-1:0] GAP_RST = 4'h1;
    localparam logic [RT_W-1:0] VCT_RT_DEF = 5'h01;

    typedef struct packed {
        logic            vld;
        logic [RT_W-1:0] rt;
        logic            tx_err;
        logic            loop_fail;
        logic            msg_err;
        logic            busy;
        logic            subsys;
        logic            term;
    } rbr_txn_t;

    typedef struct packed {
        logic            wr;
        logic            rd;
        logic            bus;
        logic [RT_W-1:0] rt;
    } rbr_wrap_t;

    typedef struct packed {
        logic done;
        logic pass;
    } rbr_wres_t;

    typedef enum logic [2:0] {
        S_IDLE, S_SCAN, S_GAP, S_RES, S_EVAL, S_UNMUTE, S_ALARM
    } rbr_state_t;
endpackage

// ==== tb/rbr_assertions.sv ====
// Port checks for the bus recovery manager
`timescale 1ns/1ps
`default_nettype none
module rbr_assertions
    import rbr_pkg::*;
#(parameter int SYNC_CYCLES = 200) (
    // Clock and reset
    input wire logic        sys_clk_in,
    input wire logic        resetn_in,
    // Watched ports
    input wire rbr_txn_t    txn_in,
    input wire rbr_wrap_t   wrap_out,
    input wire logic        mute_out,
    input wire logic        sync_out,
    input wire logic [31:0] tfl_enable_out,
    input wire logic        bus_event_out,
    input wire logic        alarm3_out,
    input wire logic        anomaly_out,
    input wire logic        sgm_wr_out
);
    logic [31:0] gap_q;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    // Cycles since the last sync pulse; bit 31 marks none seen yet
    always_ff @(posedge sys_clk_in) begin
        gap_q <= !resetn_in ? 32'h8000_0000 : sync_out ? 32'h0 : gap_q + 32'h1;
    end
    a_event_mute: assert property (bus_event_out && !alarm3_out |=> mute_out) else $error("mute late");
    a_muted_quiet: assert property (mute_out |-> tfl_enable_out == 32'h0) else $error("tfl on");
    a_anomaly_src: assert property (anomaly_out |-> $past(txn_in.vld && |txn_in[3:0])) else $error("anomaly");
    a_event_pulse: assert property (bus_event_out |=> !bus_event_out) else $error("event long");
    a_store_sync: assert property (sgm_wr_out |-> sync_out) else $error("store");
    a_wrap_muted: assert property (wrap_out.wr || wrap_out.rd |-> mute_out) else $error("wrap unmuted");
    a_sync_period: assert property (sync_out |-> gap_q[31] || gap_q == SYNC_CYCLES - 1) else $error("sync");
    a_sync_due: assert property (gap_q[31] || gap_q < SYNC_CYCLES) else $error("sync due");
endmodule
bind rbr_manager rbr_assertions #(.SYNC_CYCLES(SYNC_CYCLES)) u_chk (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .txn_in(txn_in), .wrap_out(wrap_out), .mute_out(mute_out), .sync_out(sync_out), .tfl_enable_out(tfl_enable_out),
    .bus_event_out(bus_event_out), .alarm3_out(alarm3_out), .anomaly_out(anomaly_out), .sgm_wr_out(sgm_wr_out));
`default_nettype wire

// ==== tb/rbr_rt_model.sv ====
// Remote terminals answering wrap-around read-backs
`timescale 1ns/1ps
`default_nettype none
module rbr_rt_model
    import rbr_pkg::*;
(
    input wire logic      clk_in,
    input wire logic      fail_a_in,
    input wire rbr_wrap_t wrap_in,
    output rbr_wres_t     res_out
);
    logic [1:0] d_q = 2'h0;
    logic       b_q = 1'b0;
    // Read-back three cycles after the read; pass follows the delayed read strobe outside done
    always_ff @(posedge clk_in) begin
        d_q <= {d_q[0], wrap_in.rd};
        b_q <= wrap_in.rd ? wrap_in.bus : b_q;
        res_out <= {d_q[1], d_q[1] ? !(fail_a_in && !b_q) : d_q[0]};
    end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the bus recovery manager
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rbr_pkg::*;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, fa = 0, tm = 0, tp = 0, rr = 0, st = 0, sm, sr, sp;
    logic cs = 0, rsp = 0, pk = 0, act, mute, bev, al3, an, rm, rp, sf, sb;
    logic [4:0] crt = 5'h0, ert;
    logic [2:0] sgd;
    logic [7:0] ad = 8'h0, cnt = 8'h0, pc = 8'h0, rc;
    logic [31:0] wd = 32'h0, rdo, transfer_layer;
    logic [7:0] ra [7] = '{A_CTRL, A_HEALTH, A_VALID_SET, A_VITAL, A_SURV, A_GAP, 8'h40};
    logic [31:0] rv [7] = '{32'h2, 32'h3, 32'hffff_ffff, 32'h0, 32'h0, 32'h1, 32'h0};
    rbr_txn_t tx = '0;
    rbr_wrap_t wo;
    rbr_wres_t wres;
    int fail_count = 0, n_tests = 0, nev = 0, nsf = 0, nal = 0;
    rbr_manager #(.SYNC_CYCLES(200), .RECOV_CYCLES(5000)) u_dut (.sys_clk_in(clk), .resetn_in(rstn),
        .reg_addr_in(ad), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdo), .txn_in(tx),
        .cmd_sent_in(cs), .cmd_rt_in(crt), .resp_in(rsp), .slot_tick_in(st), .wrap_res_in(wres),
        .tc_msg_sent_in(tm), .tc_pkt_sent_in(tp), .ptd_count_in(pc), .ptc_ok_in(pk),
        .reset_release_signal_in(rr), .ctx_valid_in(1'b0), .ctx_health_in(2'h0), .ctx_active_in(1'b0),
        .wrap_out(wo), .active_bus_out(act), .mute_out(mute), .sync_out(), .tfl_enable_out(transfer_layer),
        .bus_event_out(bev), .alarm3_out(al3), .subsys_fault_out(sf), .anomaly_out(an), .event_rt_out(ert),
        .rep_msg_out(rm), .rep_pkt_out(rp), .rep_count_out(rc), .sgm_wr_out(), .sgm_data_out(sgd),
        .surv_bus_out(sb));
    rbr_rt_model u_rt (.clk_in(clk), .fail_a_in(fa), .wrap_in(wo), .res_out(wres));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cnt <= cnt + 8'h1;
        st <= cnt[1:0] == 2'h0;
        nev <= nev + int'(bev);
        nsf <= nsf + int'(sf);
        nal <= nal + int'(al3);
    end
    task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {ad, wd, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        {ad, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", rdo, e);
    endtask
    task automatic flt(input rbr_txn_t t);
        @(posedge clk);
        tx <= t;
        @(posedge clk);
        tx <= '0;
        #1;
    endtask
    task automatic rec();
        int k = 0;
        {sm, sr, sp} = 3'h0;
        while (k < 4) begin
            @(posedge clk);
            #1 {sm, sr, sp} = {sm | mute, sr | rm, sp | rp};
            if (sm && !mute) k++;
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 7; i++) rreg(ra[i], rv[i]);
        wreg(A_VALID_CLR, 32'h6);
        rreg(A_VALID_SET, 32'hffff_fff9);
        @(posedge clk);
        rr <= 1'b1;
        repeat (2) @(posedge clk);
        rr <= 1'b0;
        rreg(A_VALID_SET, 32'hffff_fffb);
        wreg(A_VALID_SET, 32'h4);
        rreg(A_VALID_SET, 32'hffff_ffff);
        wreg(A_SURV, 32'h1);
        rreg(A_SURV, 32'h0);
        wreg(A_CTRL, 32'h7);
        wreg(A_SURV, 32'h1);
        rreg(A_SURV, 32'h1);
        chk("surv_bus", sb, 1'b1);
        @(posedge clk);
        {tm, tp, pc} <= {2'h3, 8'h5a};
        @(posedge clk);
        {tm, tp} <= 2'h0;
        flt('{vld: 1'b1, rt: 5'h3, tx_err: 1'b1, default: 1'b0});
        chk("bus_event", {bev, ert}, {1'b1, 5'h3});
        rec();
        chk("recovery", {sm, sr, sp, act, transfer_layer}, {4'he, 32'hffff_ffff});
        chk("rep_count", rc, 8'h5a);
        @(posedge clk);
        {tp, pc} <= {1'b1, 8'h33};
        @(posedge clk);
        {tp, pk} <= 2'h1;
        @(posedge clk);
        {pk, fa} <= 2'h1;
        flt('{vld: 1'b1, rt: 5'h7, loop_fail: 1'b1, default: 1'b0});
        rec();
        chk("switched", {act, sm, sr, sp, rc, sgd}, {4'he, 8'h33, 3'h6});
        wreg(A_HEALTH, 32'h2);
        flt('{vld: 1'b1, rt: 5'h3, tx_err: 1'b1, default: 1'b0});
        chk("alarm", {al3, bev}, 2'h3);
        wreg(A_HEALTH, 32'h3);
        flt('{vld: 1'b1, rt: 5'h4, msg_err: 1'b1, default: 1'b0});
        chk("anomaly", {an, bev, mute}, 3'h4);
        wreg(A_VALID_CLR, 32'hffff_fdff);
        @(posedge clk);
        {cs, crt} <= {1'b1, 5'h9};
        @(posedge clk);
        {cs, rsp} <= 2'h1;
        @(posedge clk);
        rsp <= 1'b0;
        repeat (NORESP_CYC + 4) @(posedge clk);
        chk("answered", nev, 3);
        cs <= 1'b1;
        @(posedge clk);
        cs <= 1'b0;
        repeat (NORESP_CYC - 1) @(posedge clk);
        #1 chk("resp_early", bev, 1'b0);
        @(posedge clk);
        #1 chk("no_resp", {bev, ert}, {1'b1, 5'h9});
        rec();
        chk("subsys", {nsf[3:0], sgd, ert}, {4'h1, 3'h4, 5'h9});
        chk("tfl_valid", transfer_layer, 32'h200);
        wreg(A_HEALTH, 32'h3);
        wreg(A_VALID_SET, 32'h1);
        flt('{vld: 1'b1, rt: 5'h0, tx_err: 1'b1, default: 1'b0});
        repeat (300) @(posedge clk);
        chk("multi_alarm", {mute, nal}, {1'b1, 32'h2});
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
